// ==== pldmr_pkg.sv ====
// shared constants and carrier types of the macrocell register array model
// assumes a single 40 MHz clock and a synchronous active-high reset
package pldmr_pkg;

  // ****************************************************************
  // array geometry
  // ****************************************************************
  localparam int NUM_CELLS = 24;
  localparam int NUM_TERMS = 17;
  localparam int BUS_W = 172;
  localparam int NUM_DED = 14;
  localparam int NUM_PRESET = 8;
  localparam int NUM_PINS = NUM_DED + NUM_CELLS;
  localparam int SUM_TERMS = 4;
  localparam int FUSE_ROWS = NUM_CELLS * NUM_TERMS + NUM_PRESET;
  localparam int PRESET_ROW = NUM_CELLS * NUM_TERMS;
  localparam int ROW_W = 9;
  localparam int CFG_ADDR_W = 5;

  // lower product term positions inside a macrocell
  localparam int T_AR1 = 12;
  localparam int T_CK1 = 13;
  localparam int T_CK2 = 14;
  localparam int T_AR2 = 15;
  localparam int T_OE = 16;

  // global bus layout: dedicated pairs first, then six lines per cell
  localparam int CELL_BASE = 2 * NUM_DED;
  localparam int CELL_STRIDE = 6;
  localparam int CLK_PIN = 0;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_PS = 25000;
  localparam int PWRUP_NS = 1000;
  localparam int PWRUP_CYC_RAW = (PWRUP_NS * 1000) / CLK_PERIOD_PS;
  localparam int PWRUP_CYC = (PWRUP_CYC_RAW < 1) ? 1 : PWRUP_CYC_RAW;
  localparam int PWRUP_CNT_W = 6;

  // ****************************************************************
  // types and reset values
  // ****************************************************************
  typedef struct packed {
    logic toggle1;     // first flop toggle type
    logic toggle2;     // second flop toggle type
    logic pinclk1;     // first flop clocked from clock pin
    logic pinclk2;     // second flop clocked from clock pin
    logic f2_from_q2;  // second feedback from flop output
    logic comb_out;    // pin shows third sum term, not first flop
    logic out_pol;     // invert output buffer
  } pldmr_cell_cfg_t;

  typedef struct packed {
    logic [NUM_DED-1:0] ded_in;
    logic [NUM_DED-1:0] ded_driven;
    logic [NUM_CELLS-1:0] io_in;
    logic [NUM_CELLS-1:0] io_driven;
    logic preload_mode;
    logic preload_clk;
    logic preload_qsel;
    logic preload_eosel;
    logic observe_mode;
  } pldmr_pins_t;

  localparam pldmr_cell_cfg_t CFG_RST = 7'h00;
  localparam logic KEEPER_RST = 1'h0;
  localparam logic LOCK_RST = 1'h0;

  // preset groups alternate four cells then two cells
  function automatic int preset_of(input int m);
    return (m / 6) * 2 + (((m % 6) >= 4) ? 1 : 0);
  endfunction

endpackage

// ==== pldmr_array.sv ====
// synchronous model of the 24-macrocell register array with test paths
// assumes pins arrive asynchronously and are filtered here; pads and
// keeper strengths are resolved outside from the out/enable pairs

// What this block does
// - after power-up every flip-flop of every macrocell is cleared low.
// - after clearing, each pin level is output polarity applied to cleared value.
// - preload loads selected registers from odd pins, high sets, low clears.
// - preload clock pulse captures pin data into a group of 12 registers.
// - select pins choose even/odd first or second flop group.
// - observe mode drives buried second flops onto pins when enabled.
// - security lock acts immediately; verify then reads all locations programmed.
// - locked device refuses preload and second flop observability.
// - keepers off by default; when on, undriven pins hold last level weakly.
// - 24 macrocells, 17 product terms each, 172 bus inputs per term.
// - five lower terms give two clears, two clocks and one output enable.
// - upper 12 terms form three sum terms of four for flops and output.
// - eight synchronous presets shared four, two, four, two across cells.
// - bus holds 14 inputs and per cell feedback, first flop, pin pairs.
// - second feedback selects second flop input value or its output.
// - legacy subset drops toggle flops, pin clocking and input feedback.
// - each flip-flop configurable as data or toggle type.
// - each flip-flop may clock from the clock pin instead of its term.
module pldmr_array
  import pldmr_pkg::*;
#(
  parameter int PWRUP_CYCLES = pldmr_pkg::PWRUP_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [pldmr_pkg::NUM_DED-1:0] ded_in,
  input wire logic [pldmr_pkg::NUM_DED-1:0] ded_driven,
  input wire logic [pldmr_pkg::NUM_CELLS-1:0] io_in,
  input wire logic [pldmr_pkg::NUM_CELLS-1:0] io_driven,
  output logic [pldmr_pkg::NUM_CELLS-1:0] io_out,
  output logic [pldmr_pkg::NUM_CELLS-1:0] io_oe,
  output logic [pldmr_pkg::NUM_PINS-1:0] kpr_level,
  output logic [pldmr_pkg::NUM_PINS-1:0] kpr_oe,
  input wire logic preload_mode,
  input wire logic preload_clk,
  input wire logic preload_qsel,
  input wire logic preload_eosel,
  input wire logic observe_mode,
  input wire logic legacy_mode,
  input wire logic prog_we,
  input wire logic [pldmr_pkg::ROW_W-1:0] prog_addr,
  input wire logic [pldmr_pkg::BUS_W-1:0] prog_data,
  input wire logic erase_all,
  input wire logic cfg_we,
  input wire logic [pldmr_pkg::CFG_ADDR_W-1:0] cfg_addr,
  input wire pldmr_pkg::pldmr_cell_cfg_t cfg_data,
  input wire logic keeper_we,
  input wire logic keeper_set,
  input wire logic lock_program,
  input wire logic [pldmr_pkg::ROW_W-1:0] verify_addr,
  output logic [pldmr_pkg::BUS_W-1:0] verify_data,
  output logic [pldmr_pkg::NUM_CELLS-1:0] first_flop_output,
  output logic [pldmr_pkg::NUM_CELLS-1:0] second_flop_output,
  output logic lock_status,
  output logic keeper_status,
  output logic pwrup_busy
);
  import pldmr_pkg::*;

  // ****************************************************************
  // pin synchroniser: three stages, change counts when 2nd and 3rd agree
  // ****************************************************************
  pldmr_pins_t pins_raw;
  pldmr_pins_t s1_ff, s2_ff, s3_ff, flt_ff;
  pldmr_pins_t nxt_flt;

  assign pins_raw = '{ded_in: ded_in, ded_driven: ded_driven,
                      io_in: io_in, io_driven: io_driven,
                      preload_mode: preload_mode,
                      preload_clk: preload_clk,
                      preload_qsel: preload_qsel,
                      preload_eosel: preload_eosel,
                      observe_mode: observe_mode};
  // disagreeing stages hold the last accepted level, so a glitch never lands
  assign nxt_flt = (s2_ff & s3_ff) | (flt_ff & (s2_ff ^ s3_ff));

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      flt_ff <= '0;
    end else begin
      s1_ff <= pins_raw;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      flt_ff <= nxt_flt;
    end
  end

  // ****************************************************************
  // fuse rows, cell configuration, keeper enable and security lock
  // ****************************************************************
  logic [BUS_W-1:0] fuse_mem [FUSE_ROWS];
  pldmr_cell_cfg_t cfg_ff [NUM_CELLS];
  logic keeper_en_ff;
  logic lock_ff;
  logic [BUS_W-1:0] verify_ff;
  wire row_ok = 32'(prog_addr) < FUSE_ROWS;
  wire vrow_ok = 32'(verify_addr) < FUSE_ROWS;

  // an erased row connects every bus line, so its term can never be true
  always_ff @(posedge clk) begin
    if (erase_all) begin
      for (int r = 0; r < FUSE_ROWS; r++) begin
        fuse_mem[r] <= '1;
      end
    end else if (prog_we && row_ok) begin
      fuse_mem[prog_addr] <= prog_data;
    end
  end

  // cell configuration words, one per macrocell
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int c = 0; c < NUM_CELLS; c++) begin
        cfg_ff[c] <= CFG_RST;
      end
    end else if (cfg_we && (32'(cfg_addr) < NUM_CELLS)) begin
      cfg_ff[cfg_addr] <= cfg_data;
    end
  end

  // keeper and lock bits; lock acts on the very next cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      keeper_en_ff <= KEEPER_RST;
      lock_ff <= LOCK_RST;
    end else begin
      if (keeper_we) begin
        keeper_en_ff <= keeper_set;
      end
      // a lock request in the erase cycle still locks: the set wins,
      // so an erase can never open a part that is being secured
      if (lock_program) begin
        lock_ff <= 1'h1;
      end else if (erase_all) begin
        lock_ff <= LOCK_RST;
      end
    end
  end

  // verify port: a locked part hides its pattern behind all ones
  always_ff @(posedge clk) begin
    if (rst) begin
      verify_ff <= '0;
    end else if (lock_ff) begin
      verify_ff <= '1;
    end else if (vrow_ok) begin
      verify_ff <= fuse_mem[verify_addr];
    end else begin
      verify_ff <= '0;
    end
  end

  // ****************************************************************
  // pin keepers
  // ****************************************************************
  logic [NUM_PINS-1:0] keep_ff;
  logic [NUM_CELLS-1:0] io_out_ff, io_oe_ff;
  wire [NUM_PINS-1:0] pin_lvl = {flt_ff.io_in, flt_ff.ded_in};
  wire [NUM_PINS-1:0] pin_drv = {flt_ff.io_driven | io_oe_ff,
                                 flt_ff.ded_driven};
  wire [NUM_PINS-1:0] pin_float = ~pin_drv & {NUM_PINS{keeper_en_ff}};
  // floating pins read as the level the keeper is holding
  wire [NUM_PINS-1:0] pin_eff = (pin_lvl & ~pin_float)
                                | (keep_ff & pin_float);

  always_ff @(posedge clk) begin
    if (rst) begin
      keep_ff <= '0;
    end else begin
      keep_ff <= (pin_lvl & pin_drv) | (keep_ff & ~pin_drv);
    end
  end

  // ****************************************************************
  // power-up clearing interval
  // ****************************************************************
  logic [PWRUP_CNT_W-1:0] pwr_cnt_ff;
  wire pwr_busy = (pwr_cnt_ff != '0);

  // flops stay clear while the board lets its clock sources settle
  always_ff @(posedge clk) begin
    if (rst) begin
      pwr_cnt_ff <= PWRUP_CNT_W'(PWRUP_CYCLES);
    end else if (pwr_busy) begin
      pwr_cnt_ff <= pwr_cnt_ff - 1'b1;
    end
  end

  // ****************************************************************
  // global bus, preset terms and test controls
  // ****************************************************************
  wire [BUS_W-1:0] gbus;
  wire [NUM_PRESET-1:0] preset_pt;
  logic [NUM_CELLS-1:0] q1_ff, q2_ff, ck1_prev_ff, ck2_prev_ff;
  logic [NUM_CELLS-1:0] f2_in_ff;
  logic pl_prev_ff;
  wire [NUM_CELLS-1:0] nxt_q1, nxt_q2, nxt_ck1, nxt_ck2, nxt_f2_in;
  wire [NUM_CELLS-1:0] nxt_out, nxt_oe;
  wire clk_pin = pin_eff[CLK_PIN];
  wire pl_allow = flt_ff.preload_mode & ~lock_ff;
  wire pl_edge = pl_allow & flt_ff.preload_clk & ~pl_prev_ff;
  wire obs_act = flt_ff.observe_mode & ~lock_ff;

  // dedicated inputs enter the bus as true/complement pairs
  genvar gi;
  generate
    for (gi = 0; gi < NUM_DED; gi++) begin : g_ded
      assign gbus[2*gi +: 2] = {~pin_eff[gi], pin_eff[gi]};
    end
    for (gi = 0; gi < NUM_PRESET; gi++) begin : g_pre
      assign preset_pt[gi] = &(gbus | ~fuse_mem[PRESET_ROW + gi]);
    end
  endgenerate

  // ****************************************************************
  // macrocells
  // ****************************************************************
  genvar gc, gt;
  generate
    for (gc = 0; gc < NUM_CELLS; gc++) begin : g_cell
      localparam int PSET = preset_of(gc);
      localparam int ODD_PIN = NUM_DED + (gc | 1);
      wire [NUM_TERMS-1:0] pt;
      wire [2:0] sum;
      wire tog1, tog2, pclk1, pclk2, src1, src2, edge1, edge2;
      wire sel1, sel2, pdata, f2, d1, d2, odata;

      // each and gate sees the whole bus through its fuse row
      for (gt = 0; gt < NUM_TERMS; gt++) begin : g_term
        assign pt[gt] = &(gbus | ~fuse_mem[gc*NUM_TERMS + gt]);
      end
      for (gt = 0; gt < 3; gt++) begin : g_sum
        assign sum[gt] = |pt[gt*SUM_TERMS +: SUM_TERMS];
      end

      // legacy subset strips toggle, pin clocking and input feedback
      assign tog1 = cfg_ff[gc].toggle1 & ~legacy_mode;
      assign tog2 = cfg_ff[gc].toggle2 & ~legacy_mode;
      assign pclk1 = cfg_ff[gc].pinclk1 & ~legacy_mode;
      assign pclk2 = cfg_ff[gc].pinclk2 & ~legacy_mode;

      // clock source per flop, edges found against last cycle's sample
      assign src1 = pclk1 ? clk_pin : pt[T_CK1];
      assign src2 = pclk2 ? clk_pin : pt[T_CK2];
      assign edge1 = src1 & ~ck1_prev_ff[gc];
      assign edge2 = src2 & ~ck2_prev_ff[gc];

      // preload group: q select picks flop, even/odd select picks cells
      // parity taken by modulo, since a bit-select of a genvar is not portable
      assign sel1 = pl_edge & ~flt_ff.preload_qsel
                    & (flt_ff.preload_eosel == 1'(gc % 2));
      assign sel2 = pl_edge & flt_ff.preload_qsel
                    & (flt_ff.preload_eosel == 1'(gc % 2));
      assign pdata = pin_eff[ODD_PIN];

      // data or toggle next value; preset wins on the flop's own edge
      assign d1 = preset_pt[PSET] ? 1'b1
                  : (tog1 ? (q1_ff[gc] ^ sum[0]) : sum[0]);
      assign d2 = preset_pt[PSET] ? 1'b1
                  : (tog2 ? (q2_ff[gc] ^ sum[1]) : sum[1]);

      // clear term first, then preload, then the clock edge
      assign nxt_q1[gc] = (pwr_busy || pt[T_AR1]) ? 1'b0
                          : sel1 ? pdata
                          : edge1 ? d1 : q1_ff[gc];
      assign nxt_q2[gc] = (pwr_busy || pt[T_AR2]) ? 1'b0
                          : sel2 ? pdata
                          : edge2 ? d2 : q2_ff[gc];
      assign nxt_ck1[gc] = src1;
      assign nxt_ck2[gc] = src2;
      assign nxt_f2_in[gc] = sum[1];

      // second feedback: flop output, or its input one cycle late
      assign f2 = (cfg_ff[gc].f2_from_q2 | legacy_mode) ? q2_ff[gc]
                  : f2_in_ff[gc];
      assign gbus[CELL_BASE + gc*CELL_STRIDE +: CELL_STRIDE] =
        {~pin_eff[NUM_DED + gc], pin_eff[NUM_DED + gc],
         ~q1_ff[gc], q1_ff[gc], ~f2, f2};

      // pin data: buried flop in observe mode, else polarity applied
      assign odata = cfg_ff[gc].comb_out ? sum[2] : q1_ff[gc];
      assign nxt_out[gc] = obs_act ? q2_ff[gc]
                           : (odata ^ cfg_ff[gc].out_pol);
      assign nxt_oe[gc] = pt[T_OE] & ~pwr_busy;
    end
  endgenerate

  // ****************************************************************
  // register bank and pin drivers
  // ****************************************************************
  // input feedback is registered to keep the array free of loops
  always_ff @(posedge clk) begin
    if (rst) begin
      q1_ff <= '0;
      q2_ff <= '0;
      ck1_prev_ff <= '0;
      ck2_prev_ff <= '0;
      f2_in_ff <= '0;
      pl_prev_ff <= 1'h0;
    end else begin
      q1_ff <= nxt_q1;
      q2_ff <= nxt_q2;
      ck1_prev_ff <= nxt_ck1;
      ck2_prev_ff <= nxt_ck2;
      f2_in_ff <= nxt_f2_in;
      pl_prev_ff <= flt_ff.preload_clk;
    end
  end

  // pin drivers are registered, one cycle behind the array
  always_ff @(posedge clk) begin
    if (rst) begin
      io_out_ff <= '0;
      io_oe_ff <= '0;
    end else begin
      io_out_ff <= nxt_out;
      io_oe_ff <= nxt_oe;
    end
  end

  assign io_out = io_out_ff;
  assign io_oe = io_oe_ff;
  assign kpr_level = keep_ff;
  assign kpr_oe = pin_float; // weak drive only where nothing else drives
  assign verify_data = verify_ff;
  assign first_flop_output = q1_ff;
  assign second_flop_output = q2_ff;
  assign lock_status = lock_ff;
  assign keeper_status = keeper_en_ff;
  assign pwrup_busy = pwr_busy;

endmodule

// ==== pldmr_array_assertions.sv ====
// checker for the macrocell register array, bound to its top module
// assumes one clock and a synchronous active-high reset
module pldmr_array_chk
  import pldmr_pkg::*;
#(
  parameter int PWRUP_CYCLES = pldmr_pkg::PWRUP_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic observe_mode,
  input wire logic erase_all,
  input wire logic lock_program,
  input wire logic [pldmr_pkg::ROW_W-1:0] verify_addr,
  input wire logic [pldmr_pkg::BUS_W-1:0] verify_data,
  input wire logic [pldmr_pkg::NUM_CELLS-1:0] io_out,
  input wire logic [pldmr_pkg::NUM_CELLS-1:0] io_oe,
  input wire logic [pldmr_pkg::NUM_PINS-1:0] kpr_oe,
  input wire logic [pldmr_pkg::NUM_CELLS-1:0] first_flop_output,
  input wire logic [pldmr_pkg::NUM_CELLS-1:0] second_flop_output,
  input wire logic lock_status,
  input wire logic keeper_status,
  input wire logic pwrup_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  // ********
  // checks
  // ********
  // busy stretch length, kept in a counter so no long repetition unrolls
  logic [7:0] busy_cnt_ff;
  always_ff @(posedge clk) begin
    if (rst || !pwrup_busy) begin
      busy_cnt_ff <= 8'h00;
    end else begin
      busy_cnt_ff <= busy_cnt_ff + 8'h01;
    end
  end
  a_pwrup_clear: assert property (
    pwrup_busy |-> first_flop_output == '0 && second_flop_output == '0)
    else $error("flops not low while clearing");
  a_pwrup_no_oe: assert property (
    pwrup_busy |-> io_oe == '0)
    else $error("pin enabled while clearing");
  a_pwrup_length: assert property (
    $fell(pwrup_busy) |-> busy_cnt_ff == PWRUP_CYCLES)
    else $error("clearing interval has wrong length");
  a_lock_takes: assert property (
    lock_program |=> lock_status)
    else $error("lock not set the next cycle");
  a_lock_holds: assert property (
    lock_status && !erase_all |=> lock_status)
    else $error("lock dropped without erase");
  a_lock_verify: assert property (
    lock_status |=> verify_data == '1)
    else $error("verify not all ones while locked");
  a_observe_q2: assert property (
    (observe_mode && !lock_status)[*6] |=>
      io_out == $past(second_flop_output))
    else $error("observe does not show second flops");
  a_keeper_idle: assert property (
    !keeper_status |-> kpr_oe == '0)
    else $error("keeper drives while disabled");
  a_reset_state: assert property (
    $past(rst) |-> !keeper_status && !lock_status && verify_data == '0)
    else $error("keeper, lock or verify not cleared by reset");
  a_verify_range: assert property (
    !lock_status && verify_addr >= FUSE_ROWS |=>
      lock_status || verify_data == '0)
    else $error("unmapped row does not read zero");
  // main scenarios reached
  c_pwrup_done: cover property ($fell(pwrup_busy));
  c_observe: cover property ((observe_mode && !lock_status)[*6]);
  c_lock: cover property (lock_program ##1 lock_status);
endmodule

bind pldmr_array pldmr_array_chk #(.PWRUP_CYCLES(PWRUP_CYCLES)) u_chk (
  .clk(clk), .rst(rst), .observe_mode(observe_mode),
  .erase_all(erase_all), .lock_program(lock_program),
  .verify_addr(verify_addr), .verify_data(verify_data),
  .io_out(io_out), .io_oe(io_oe), .kpr_oe(kpr_oe),
  .first_flop_output(first_flop_output),
  .second_flop_output(second_flop_output), .lock_status(lock_status),
  .keeper_status(keeper_status), .pwrup_busy(pwrup_busy)
);

// ==== pldmr_board.sv ====
// board and tester model that drives and resolves the I/O pads
// assumes the array's out/enable pairs and the bench clock
module pldmr_board
  import pldmr_pkg::*;
(
  input wire logic clk,
  input wire logic [pldmr_pkg::NUM_CELLS-1:0] io_out,
  input wire logic [pldmr_pkg::NUM_CELLS-1:0] io_oe,
  input wire logic [pldmr_pkg::NUM_CELLS-1:0] kpr_level,
  input wire logic [pldmr_pkg::NUM_CELLS-1:0] kpr_oe,
  input wire logic [pldmr_pkg::NUM_CELLS-1:0] drv_val,
  input wire logic [pldmr_pkg::NUM_CELLS-1:0] drv_en,
  output logic [pldmr_pkg::NUM_CELLS-1:0] io_in,
  output logic [pldmr_pkg::NUM_CELLS-1:0] io_driven
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********
  // pads
  // ********
  // a floating pad flips every cycle so it never passes for a held level
  logic [NUM_CELLS-1:0] junk_ff = 24'h00_0000;
  always_ff @(posedge clk) begin
    junk_ff <= ~junk_ff;
  end
  // device enable wins, then tester level, then keeper, else floating
  assign io_driven = drv_en;
  assign io_in = (io_oe & io_out) | (~io_oe & drv_en & drv_val)
    | (~io_oe & ~drv_en & kpr_oe & kpr_level)
    | (~io_oe & ~drv_en & ~kpr_oe & junk_ff);
endmodule

// ==== testbench.sv ====
// bench for the macrocell register array: task calls with expectations
// assumes the board model and the bound checker are compiled first
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import pldmr_pkg::*;
  localparam int PW = 3;
  logic clk, rst, preload_mode, preload_clk, preload_qsel, preload_eosel;
  logic observe_mode, legacy_mode, prog_we, erase_all, cfg_we, keeper_we;
  logic keeper_set, lock_program, lock_status, keeper_status, pwrup_busy;
  logic [NUM_DED-1:0] ded_in, ded_driven;
  logic [NUM_CELLS-1:0] io_in, io_driven, io_out, io_oe, drv_val, drv_en;
  logic [NUM_CELLS-1:0] q1, q2, e1, e2, pat;
  logic [NUM_PINS-1:0] kpr_level, kpr_oe;
  logic [ROW_W-1:0] prog_addr, verify_addr;
  logic [BUS_W-1:0] prog_data, verify_data;
  logic [CFG_ADDR_W-1:0] cfg_addr;
  pldmr_cell_cfg_t cfg_data;
  int err_total, n_compared, n;
  pldmr_array #(.PWRUP_CYCLES(PW)) dut (
    .clk(clk), .rst(rst), .ded_in(ded_in), .ded_driven(ded_driven),
    .io_in(io_in), .io_driven(io_driven), .io_out(io_out), .io_oe(io_oe),
    .kpr_level(kpr_level), .kpr_oe(kpr_oe), .preload_mode(preload_mode),
    .preload_clk(preload_clk), .preload_qsel(preload_qsel),
    .preload_eosel(preload_eosel), .observe_mode(observe_mode),
    .legacy_mode(legacy_mode), .prog_we(prog_we), .prog_addr(prog_addr),
    .prog_data(prog_data), .erase_all(erase_all), .cfg_we(cfg_we),
    .cfg_addr(cfg_addr), .cfg_data(cfg_data), .keeper_we(keeper_we),
    .keeper_set(keeper_set), .lock_program(lock_program),
    .verify_addr(verify_addr), .verify_data(verify_data),
    .first_flop_output(q1), .second_flop_output(q2),
    .lock_status(lock_status), .keeper_status(keeper_status),
    .pwrup_busy(pwrup_busy)
  );
  pldmr_board board (
    .clk(clk), .io_out(io_out), .io_oe(io_oe),
    .kpr_level(kpr_level[NUM_PINS-1:NUM_DED]),
    .kpr_oe(kpr_oe[NUM_PINS-1:NUM_DED]), .drv_val(drv_val),
    .drv_en(drv_en), .io_in(io_in), .io_driven(io_driven)
  );
  // ********
  // tasks
  // ********
  // free-running 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task step(input int k);
    repeat (k) @(posedge clk);
  endtask
  task chk(input string nm, input logic [BUS_W-1:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task tend(input string nm);
    $display("test %s done, mismatches so far %0d", nm, err_total);
  endtask
  task report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // each write strobe stands one edge, then one idle edge
  task prog(input int row, input logic [BUS_W-1:0] d);
    prog_we <= 1'b1;
    prog_addr <= ROW_W'(row);
    prog_data <= d;
    step(1);
    prog_we <= 1'b0;
    step(1);
  endtask
  task cfg(input int c, input logic [6:0] v);
    cfg_we <= 1'b1;
    cfg_addr <= CFG_ADDR_W'(c);
    cfg_data <= pldmr_cell_cfg_t'(v);
    step(1);
    cfg_we <= 1'b0;
    step(1);
  endtask
  // pin pulses last several cycles so the input filter keeps them
  task pulse(input int i);
    ded_in[i] <= 1'b1;
    step(4);
    ded_in[i] <= 1'b0;
    step(8);
  endtask
  task pl(input int g, input logic [NUM_CELLS-1:0] p);
    drv_en <= 24'hFF_FFFF;
    drv_val <= p;
    preload_qsel <= g[0];
    preload_eosel <= g[1];
    preload_mode <= 1'b1;
    step(6);
    preload_clk <= 1'b1;
    step(4);
    preload_clk <= 1'b0;
    step(8);
  endtask
  // ********
  // tests
  // ********
  initial begin
    {preload_mode, preload_clk, preload_qsel, preload_eosel} = '0;
    {observe_mode, legacy_mode, prog_we, erase_all, cfg_we} = '0;
    {keeper_we, keeper_set, lock_program, ded_in, drv_val, drv_en} = '0;
    {prog_addr, verify_addr, prog_data, cfg_addr, cfg_data} = '0;
    {e1, e2, pat} = '0;
    ded_driven = '1;
    err_total = 0;
    n_compared = 0;
    rst = 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    // fuse rows power up unknown: erase them inside the clearing interval
    erase_all <= 1'b1;
    step(1);
    erase_all <= 1'b0;
    step(1);
    n = 0;
    // clock sources stay still until clearing ends
    while (pwrup_busy !== 1'b0 && n < 100) begin
      step(1);
      n++;
    end
    if (n >= 100) begin
      err_total++;
      report_and_stop();
    end
    chk("q1", BUS_W'(q1), '0);
    chk("q2", BUS_W'(q2), '0);
    chk("io_oe", BUS_W'(io_oe), '0);
    chk("io_out", BUS_W'(io_out), '0);
    chk("keeper", BUS_W'(keeper_status), '0);
    tend("reset");
    keeper_set <= 1'b1;
    keeper_we <= 1'b1;
    ded_in[5] <= 1'b1;
    step(1);
    keeper_we <= 1'b0;
    step(8);
    ded_driven[5] <= 1'b0;
    ded_in[5] <= 1'b0;
    step(8);
    chk("keep_on", BUS_W'(keeper_status), 1);
    chk("keep_oe", BUS_W'(kpr_oe[5]), 1);
    chk("keep_lvl", BUS_W'(kpr_level[5]), 1);
    tend("keeper");
    erase_all <= 1'b1;
    step(1);
    erase_all <= 1'b0;
    prog(0, '0);
    prog(T_CK1, BUS_W'(1) << 4);
    cfg(0, 7'h40);
    pulse(2);
    chk("toggle1", BUS_W'(q1[0]), 1);
    pulse(2);
    chk("toggle2", BUS_W'(q1[0]), 0);
    cfg(0, 7'h50);
    pulse(0);
    chk("pinclk", BUS_W'(q1[0]), 1);
    legacy_mode <= 1'b1;
    pulse(0);
    chk("legacy_pin", BUS_W'(q1[0]), 1);
    pulse(2);
    chk("legacy_d", BUS_W'(q1[0]), 1);
    legacy_mode <= 1'b0;
    prog(PRESET_ROW, '0);
    pulse(0);
    chk("preset", BUS_W'(q1[0]), 1);
    prog(PRESET_ROW, '1);
    prog(T_AR1, '0);
    step(8);
    chk("clear", BUS_W'(q1[0]), 0);
    prog(T_AR1, '1);
    tend("clocking");
    for (int g = 0; g < 4; g++) begin
      pat = 24'h96_5A3C ^ {8{g[2:0]}};
      pl(g, pat);
      for (int c = 0; c < NUM_CELLS; c++) begin
        if (c % 2 == g / 2 && g % 2 == 1) e2[c] = pat[c | 1];
        if (c % 2 == g / 2 && g % 2 == 0) e1[c] = pat[c | 1];
      end
      chk("pre_q1", BUS_W'(q1), BUS_W'(e1));
      chk("pre_q2", BUS_W'(q2), BUS_W'(e2));
    end
    preload_mode <= 1'b0;
    drv_en <= '0;
    tend("preload");
    for (int c = 0; c < NUM_CELLS; c++) begin
      prog(c * NUM_TERMS + T_OE, '0);
    end
    cfg(5, 7'h01);
    step(4);
    chk("oe", BUS_W'(io_oe), BUS_W'(24'hFF_FFFF));
    chk("pol", BUS_W'(io_out), BUS_W'(e1 ^ 24'h00_0020));
    observe_mode <= 1'b1;
    step(8);
    chk("observe", BUS_W'(io_out), BUS_W'(e2));
    observe_mode <= 1'b0;
    tend("observe");
    verify_addr <= ROW_W'(T_CK1);
    step(3);
    chk("verify", verify_data, BUS_W'(1) << 4);
    verify_addr <= ROW_W'(FUSE_ROWS);
    step(3);
    chk("vrange", verify_data, '0);
    tend("verify");
    erase_all <= 1'b1;
    step(1);
    erase_all <= 1'b0;
    lock_program <= 1'b1;
    step(1);
    lock_program <= 1'b0;
    step(3);
    chk("locked", BUS_W'(lock_status), 1);
    chk("vlock", verify_data, '1);
    pl(0, ~e1);
    preload_mode <= 1'b0;
    drv_en <= '0;
    chk("lk_pre", BUS_W'(q1), BUS_W'(e1));
    observe_mode <= 1'b1;
    step(8);
    chk("lk_obs", BUS_W'(io_out), BUS_W'(e1 ^ 24'h00_0020));
    tend("lock");
    // cell 1 shows cell 0's second feedback through its third sum term
    prog(4, '0);
    prog(NUM_TERMS + 8, BUS_W'(1) << CELL_BASE);
    cfg(1, 7'h02);
    step(4);
    chk("f2_in", BUS_W'(io_out[1]), 1);
    cfg(0, 7'h04);
    step(4);
    chk("f2_q2", BUS_W'(io_out[1]), BUS_W'(e2[0]));
    tend("feedback");
    report_and_stop();
  end
endmodule
